// File: paq_pkg.sv
/*
 * Package for the PWM action qualifier: register offsets, field layout,
 * reset values and action encodings.
 * Assumes a 16-bit register port with word indices as offsets.
 */
package paq_pkg;

   // -----------------------------------------------------------------
   // Register map (word index on the register port)
   // -----------------------------------------------------------------
   localparam int          PAQ_AW           = 4;
   localparam logic [3:0]  PAQ_OFS_CTL_A    = 4'h0;
   localparam logic [3:0]  PAQ_OFS_CTL_B    = 4'h1;
   localparam logic [3:0]  PAQ_OFS_STATUS   = 4'h2;
   localparam logic [3:0]  PAQ_OFS_CMP_A    = 4'h3;
   localparam logic [3:0]  PAQ_OFS_CMP_B    = 4'h4;

   // -----------------------------------------------------------------
   // Field layout of each action control register
   // -----------------------------------------------------------------
   localparam int          PAQ_FLD_ZERO     = 0;
   localparam int          PAQ_FLD_PERIOD   = 2;
   localparam int          PAQ_FLD_CA_UP    = 4;
   localparam int          PAQ_FLD_CA_DOWN  = 6;
   localparam int          PAQ_FLD_CB_UP    = 8;
   localparam int          PAQ_FLD_CB_DOWN  = 10;
   localparam logic [15:0] PAQ_CTL_MASK     = 16'h0FFF;
   localparam logic [15:0] PAQ_CTL_RESET    = 16'h0000;
   localparam logic [15:0] PAQ_CMP_RESET    = 16'h0000;
   localparam logic        PAQ_OUT_RESET    = 1'b0;

   // -----------------------------------------------------------------
   // Direction and action encodings
   // -----------------------------------------------------------------
   localparam logic        PAQ_DIR_DOWN     = 1'b0;
   localparam logic        PAQ_DIR_UP       = 1'b1;

   typedef enum logic [1:0] {
      PAQ_ACT_NONE   = 2'h0,
      PAQ_ACT_LOW    = 2'h1,
      PAQ_ACT_HIGH   = 2'h2,
      PAQ_ACT_TOGGLE = 2'h3
   } paq_action_t;

endpackage

// File: paq_output_qual.sv
/*
 * One output of the action qualifier: picks one action from the six event
 * fields by fixed priority and applies it to the registered output.
 * Assumes event inputs are single-cycle qualifiers on REF_CLK.
 */
`timescale 1ns/100ps
`default_nettype none

module paq_output_qual
   import paq_pkg::*;
(
   input  wire logic        clk,        // Time-base clock
   input  wire logic        rst_n,      // Synchronous reset, active low
   input  wire logic [15:0] ctl,        // Action control register
   input  wire logic        ev_zero,    // Counter equals zero
   input  wire logic        ev_period,  // Counter equals period
   input  wire logic        ev_ca_up,   // Compare A match, counting up
   input  wire logic        ev_ca_down, // Compare A match, counting down
   input  wire logic        ev_cb_up,   // Compare B match, counting up
   input  wire logic        ev_cb_down, // Compare B match, counting down
   output logic             pwm_out     // Qualified output level
);

   paq_action_t act;
   logic        out_q;
   logic        out_d;

   // -----------------------------------------------------------------
   // Priority select: compare B down highest, zero lowest
   // -----------------------------------------------------------------
   always_comb begin
      act = PAQ_ACT_NONE;
      if (ev_cb_down) begin
         act = paq_action_t'(ctl[PAQ_FLD_CB_DOWN +: 2]);
      end else if (ev_cb_up) begin
         act = paq_action_t'(ctl[PAQ_FLD_CB_UP +: 2]);
      end else if (ev_ca_down) begin
         act = paq_action_t'(ctl[PAQ_FLD_CA_DOWN +: 2]);
      end else if (ev_ca_up) begin
         act = paq_action_t'(ctl[PAQ_FLD_CA_UP +: 2]);
      end else if (ev_period) begin
         act = paq_action_t'(ctl[PAQ_FLD_PERIOD +: 2]);
      end else if (ev_zero) begin
         act = paq_action_t'(ctl[PAQ_FLD_ZERO +: 2]);
      end
   end

   always_comb begin
      case (act)
         PAQ_ACT_NONE:   out_d = out_q;
         PAQ_ACT_LOW:    out_d = 1'b0;
         PAQ_ACT_HIGH:   out_d = 1'b1;
         PAQ_ACT_TOGGLE: out_d = ~out_q;
         default:        out_d = out_q;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_q <= PAQ_OUT_RESET;
      end else begin
         out_q <= out_d;
      end
   end

   assign pwm_out = out_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   zero_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ev_zero && !ev_period && !ev_ca_up && !ev_ca_down && !ev_cb_up && !ev_cb_down
       && ctl[1:0] == 2'h1) |=> !pwm_out)
      else $error("zero event with clear code did not drive low");

   cbd_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ev_cb_down && ctl[11:10] == 2'h3) |=> (pwm_out != $past(pwm_out)))
      else $error("compare B down toggle did not invert output");

   idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(ev_zero || ev_period || ev_ca_up || ev_ca_down || ev_cb_up || ev_cb_down)
      |=> $stable(pwm_out))
      else $error("output changed without an event");

endmodule

`default_nettype wire

// File: paq_top.sv
/*
 * PWM action qualifier top: register port, match-event generation from the
 * time-base counter, and two output qualifiers (A and B).
 * Assumes counter, period and direction come from logic on REF_CLK.
 */
// Functional notes
// - Action code 0 holds, 1 drives low, 2 drives high, 3 toggles.
// - Bits 11-10 act on compare B match while counting down.
// - Bits 9-8 act on compare B match while counting up.
// - Bits 7-6 act on compare A match while counting down.
// - Bits 5-4 act on compare A match while counting up.
// - Bits 3-2 act when the counter reaches the period.
// - Bits 1-0 act when the counter reaches zero.
// - In up-down mode, direction is down at the period match.
// - In up-down mode, direction is up at the zero match.
// - A second register, same layout, drives output B.
// - Code 2 drives the output high on its event.
// - Compare B match raised whenever compare B equals the counter.
`timescale 1ns/100ps
`default_nettype none

module paq_top
   import paq_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input  wire logic             REF_CLK,     // Time-base clock, 200 MHz
   input  wire logic             RSTN,        // Synchronous reset, active low
   input  wire logic [PAQ_AW-1:0] REG_ADDR,   // Register word index
   input  wire logic [15:0]      REG_WDATA,   // Write data
   input  wire logic             REG_WR,      // Write strobe
   input  wire logic             REG_RD,      // Read strobe
   output logic      [15:0]      REG_RDATA,   // Read data, cycle after strobe
   input  wire logic [CNT_W-1:0] TB_COUNT,    // Time-base counter value
   input  wire logic [CNT_W-1:0] TB_PERIOD,   // Period value
   input  wire logic             TB_DIR,      // Count direction, 1 up
   input  wire logic             TB_UPDOWN,   // Up-down counting mode
   output logic                  PWM_OUT_A,   // Output A
   output logic                  PWM_OUT_B    // Output B
);

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic [15:0]      ctl_a_q, ctl_a_d;
   logic [15:0]      ctl_b_q, ctl_b_d;
   logic [CNT_W-1:0] cmp_a_q, cmp_a_d;
   logic [CNT_W-1:0] cmp_b_q, cmp_b_d;
   logic [15:0]      rdata_q, rdata_d;

   always_comb begin
      ctl_a_d = ctl_a_q;
      ctl_b_d = ctl_b_q;
      cmp_a_d = cmp_a_q;
      cmp_b_d = cmp_b_q;
      rdata_d = 16'h0000;
      if (REG_WR) begin
         case (REG_ADDR)
            PAQ_OFS_CTL_A: ctl_a_d = REG_WDATA & PAQ_CTL_MASK;
            PAQ_OFS_CTL_B: ctl_b_d = REG_WDATA & PAQ_CTL_MASK;
            PAQ_OFS_CMP_A: cmp_a_d = REG_WDATA[CNT_W-1:0];
            PAQ_OFS_CMP_B: cmp_b_d = REG_WDATA[CNT_W-1:0];
            default:       ;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            PAQ_OFS_CTL_A:  rdata_d = ctl_a_q;
            PAQ_OFS_CTL_B:  rdata_d = ctl_b_q;
            PAQ_OFS_STATUS: rdata_d = {14'h0000, PWM_OUT_B, PWM_OUT_A};
            PAQ_OFS_CMP_A:  rdata_d = 16'(cmp_a_q);
            PAQ_OFS_CMP_B:  rdata_d = 16'(cmp_b_q);
            default:        rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         ctl_a_q <= PAQ_CTL_RESET;
         ctl_b_q <= PAQ_CTL_RESET;
         cmp_a_q <= CNT_W'(PAQ_CMP_RESET);
         cmp_b_q <= CNT_W'(PAQ_CMP_RESET);
         rdata_q <= 16'h0000;
      end else begin
         ctl_a_q <= ctl_a_d;
         ctl_b_q <= ctl_b_d;
         cmp_a_q <= cmp_a_d;
         cmp_b_q <= cmp_b_d;
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;

   // -----------------------------------------------------------------
   // Match events and effective direction
   // -----------------------------------------------------------------
   logic at_zero, at_period, eff_dir;
   logic ca_match, cb_match;
   logic ev_ca_up, ev_ca_down, ev_cb_up, ev_cb_down;

   always_comb begin
      at_zero   = (TB_COUNT == '0);
      at_period = (TB_COUNT == TB_PERIOD);
      eff_dir   = TB_DIR;
      if (TB_UPDOWN && at_period) begin
         eff_dir = PAQ_DIR_DOWN;
      end else if (TB_UPDOWN && at_zero) begin
         eff_dir = PAQ_DIR_UP;
      end
      ca_match   = (TB_COUNT == cmp_a_q);
      cb_match   = (TB_COUNT == cmp_b_q);
      ev_ca_up   = ca_match && (eff_dir == PAQ_DIR_UP);
      ev_ca_down = ca_match && (eff_dir == PAQ_DIR_DOWN);
      ev_cb_up   = cb_match && (eff_dir == PAQ_DIR_UP);
      ev_cb_down = cb_match && (eff_dir == PAQ_DIR_DOWN);
   end

   // -----------------------------------------------------------------
   // Output qualifiers A and B
   // -----------------------------------------------------------------
   paq_output_qual u_qual_a (
      .clk        (REF_CLK),
      .rst_n      (RSTN),
      .ctl        (ctl_a_q),
      .ev_zero    (at_zero),
      .ev_period  (at_period),
      .ev_ca_up   (ev_ca_up),
      .ev_ca_down (ev_ca_down),
      .ev_cb_up   (ev_cb_up),
      .ev_cb_down (ev_cb_down),
      .pwm_out    (PWM_OUT_A)
   );

   paq_output_qual u_qual_b (
      .clk        (REF_CLK),
      .rst_n      (RSTN),
      .ctl        (ctl_b_q),
      .ev_zero    (at_zero),
      .ev_period  (at_period),
      .ev_ca_up   (ev_ca_up),
      .ev_ca_down (ev_ca_down),
      .ev_cb_up   (ev_cb_up),
      .ev_cb_down (ev_cb_down),
      .pwm_out    (PWM_OUT_B)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   period_dir_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (TB_UPDOWN && at_period && ca_match && !cb_match && ctl_a_q[7:6] == 2'h2
       && ctl_a_q[11:8] == 4'h0) |=> PWM_OUT_A)
      else $error("period match not treated as counting down");

   zero_dir_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (TB_UPDOWN && at_zero && !at_period && ca_match && !cb_match && ctl_a_q[5:4] == 2'h1
       && ctl_a_q[11:6] == 6'h00) |=> !PWM_OUT_A)
      else $error("zero match not treated as counting up");

   out_b_low_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (at_period && !ca_match && !cb_match && ctl_b_q[3:2] == 2'h1) |=> !PWM_OUT_B)
      else $error("output B not cleared on period code 1");

   cau_high_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (ev_ca_up && !cb_match && ctl_a_q[5:4] == 2'h2) |=> PWM_OUT_A)
      else $error("compare A up set did not drive A high");

   cbu_pri_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (ev_cb_up && ctl_b_q[9:8] == 2'h1) |=> !PWM_OUT_B)
      else $error("compare B up clear lost to lower priority");

   rd_data_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (REG_RD && REG_ADDR == PAQ_OFS_CTL_A && !$past(REG_WR)) |=>
      (REG_RDATA == $past(ctl_a_q)))
      else $error("read data of control A wrong");

   rd_idle_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !REG_RD |=> (REG_RDATA == 16'h0000))
      else $error("read data not zero outside a read");

   ctl_rsvd_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (ctl_a_q[15:12] == 4'h0) && (ctl_b_q[15:12] == 4'h0))
      else $error("reserved control bits not zero");

   cbd_high_b_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (ev_cb_down && ctl_b_q[11:10] == 2'h2) |=> PWM_OUT_B)
      else $error("compare B down set did not drive B high");

   cad_low_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (ev_ca_down && !cb_match && ctl_a_q[7:6] == 2'h1) |=> !PWM_OUT_A)
      else $error("compare A down clear did not drive A low");

   prd_toggle_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (at_period && !ca_match && !cb_match && ctl_a_q[3:2] == 2'h3)
      |=> (PWM_OUT_A != $past(PWM_OUT_A)))
      else $error("period toggle did not invert output A");

   cb_event_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (TB_COUNT == cmp_b_q) |-> (ev_cb_up || ev_cb_down))
      else $error("compare B match raised no event");

endmodule

`default_nettype wire

// File: paq_tb_counter.sv
/*
 * Time-base counter model: up or up-down counting against a period.
 * Assumes period and mode are driven by the bench on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module paq_tb_counter (
   input  wire logic        clk,    // Time-base clock
   input  wire logic        rst_n,  // Synchronous reset, active low
   input  wire logic [15:0] period, // Period value
   input  wire logic        updown, // Up-down mode
   output logic      [15:0] count,  // Counter value
   output logic             dir     // 1 up, 0 down
);
   logic [15:0] cnt_q;
   logic        up_q;

   assign count = cnt_q;
   assign dir   = updown ? up_q : 1'b1;

   // Direction lags the turn by a cycle, as in a real counter
   always_ff @(posedge clk) begin
      if (!rst_n || (!updown && cnt_q >= period)) begin
         cnt_q <= 16'h0000;
         up_q  <= 1'b1;
      end else if (!updown) begin
         cnt_q <= cnt_q + 16'h0001;
      end else if (up_q ? cnt_q >= period : cnt_q == 16'h0000) begin
         up_q  <= ~up_q;
         cnt_q <= up_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end else begin
         cnt_q <= up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
/*
 * Self-checking bench for the action qualifier with a reference model.
 * Assumes the counter model drives count and direction every cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import paq_pkg::*;
   logic        ref_clk, rstn, reg_wr, reg_rd, tb_updown, tb_dir, out_a, out_b;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, tb_count, tb_period, m_ca, m_cb, per, ca;
   logic [15:0] m_ctl [2];
   logic [1:0]  m_out;
   logic [1:0]  qo [$];
   logic [15:0] qr [$];
   int          errors = 0;
   int          num_checks = 0;
   int          seed = 32'h747466c8;

   paq_top #(.CNT_W(16)) u_paq_top (.REF_CLK(ref_clk), .RSTN(rstn), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .TB_COUNT(tb_count), .TB_PERIOD(tb_period), .TB_DIR(tb_dir), .TB_UPDOWN(tb_updown),
      .PWM_OUT_A(out_a), .PWM_OUT_B(out_b));
   paq_tb_counter u_paq_tb_counter (.clk(ref_clk), .rst_n(rstn), .period(tb_period),
      .updown(tb_updown), .count(tb_count), .dir(tb_dir));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // --------------------------------------------------------------
   // Reference model and scoreboard
   // --------------------------------------------------------------
   function automatic logic [1:0] pick(logic [15:0] c, logic [5:0] ev);
      for (int i = 5; i >= 0; i--) begin
         if (ev[i]) return c[2*i +: 2];
      end
      return 2'h0;
   endfunction

   function automatic logic apply(logic [1:0] a, logic o);
      return a == 2'h1 ? 1'b0 : a == 2'h2 ? 1'b1 : a == 2'h3 ? ~o : o;
   endfunction

   always @(posedge ref_clk) begin : model
      logic       z, p, d;
      logic [5:0] ev;
      logic [15:0] r;
      z = tb_count == 16'h0000;
      p = tb_count == tb_period;
      d = tb_updown ? (p ? PAQ_DIR_DOWN : z ? PAQ_DIR_UP : tb_dir) : tb_dir;
      ev = {tb_count == m_cb && !d, tb_count == m_cb && d,
            tb_count == m_ca && !d, tb_count == m_ca && d, p, z};
      r = 16'h0000;
      if (!rstn) begin
         m_ctl[0] = PAQ_CTL_RESET;
         m_ctl[1] = PAQ_CTL_RESET;
         m_ca = PAQ_CMP_RESET;
         m_cb = PAQ_CMP_RESET;
         m_out = {PAQ_OUT_RESET, PAQ_OUT_RESET};
      end else begin
         if (reg_rd) begin
            case (reg_addr)
               PAQ_OFS_CTL_A:  r = m_ctl[0];
               PAQ_OFS_CTL_B:  r = m_ctl[1];
               PAQ_OFS_STATUS: r = {14'h0000, m_out};
               PAQ_OFS_CMP_A:  r = m_ca;
               PAQ_OFS_CMP_B:  r = m_cb;
               default:        r = 16'h0000;
            endcase
         end
         for (int k = 0; k < 2; k++) m_out[k] = apply(pick(m_ctl[k], ev), m_out[k]);
         if (reg_wr) begin
            case (reg_addr)
               PAQ_OFS_CTL_A: m_ctl[0] = reg_wdata & PAQ_CTL_MASK;
               PAQ_OFS_CTL_B: m_ctl[1] = reg_wdata & PAQ_CTL_MASK;
               PAQ_OFS_CMP_A: m_ca = reg_wdata;
               PAQ_OFS_CMP_B: m_cb = reg_wdata;
               default:       r = r;
            endcase
         end
      end
      qo.push_back(m_out);
      qr.push_back(r);
   end

   task automatic chk_out(logic [1:0] e, logic [1:0] a);
      num_checks++;
      if (a !== e) begin
         errors++;
         $display("MISMATCH out t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   task automatic chk_rd(logic [15:0] e, logic [15:0] a);
      num_checks++;
      if (a !== e) begin
         errors++;
         $display("MISMATCH rd t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   always @(negedge ref_clk) begin
      if (qo.size() > 0) begin
         chk_out(qo.pop_front(), {out_b, out_a});
         chk_rd(qr.pop_front(), reg_rdata);
      end
   end

   // --------------------------------------------------------------
   // Stimulus
   // --------------------------------------------------------------
   task automatic bus(logic w, logic r, logic [3:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      tb_period = 16'h0008;
      tb_updown = 1'b0;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      // Reset values and unmapped indices
      for (int a = 0; a < 16; a++) bus(1'b0, 1'b1, a[3:0], 16'h0000);
      $display("Test reset_map done");
      for (int t = 0; t < 24; t++) begin
         if (t == 12) begin
            rstn <= 1'b0;
            repeat (2) @(posedge ref_clk);
            rstn <= 1'b1;
         end
         per = 16'h0004 + 16'($random(seed) & 15);
         ca = 16'h0001 + 16'($unsigned($random(seed) & 255) % per);
         tb_updown <= t[0];
         tb_period <= per;
         // Compare B one above compare A, except for A at per-1 or per, gives back-to-back events
         bus(1'b1, 1'b0, PAQ_OFS_CMP_A, ca);
         bus(1'b1, 1'b0, PAQ_OFS_CMP_B, ca % (per - 1) + 16'h0001);
         bus(1'b1, 1'b0, PAQ_OFS_CTL_A, 16'($random(seed)));
         bus(1'b1, 1'b0, PAQ_OFS_CTL_B, 16'($random(seed)));
         for (int a = 0; a < 6; a++) bus(1'b0, 1'b1, a[3:0], 16'h0000);
         bus(1'b0, 1'b0, 4'h0, 16'h0000);
         repeat (4 * per) @(posedge ref_clk);
         $display("Test run %0d done", t);
      end
      repeat (2) @(posedge ref_clk);
      end_sim();
   end

   initial begin
      repeat (10000) @(posedge ref_clk);
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
